// *** include/srx_pkg.sv ***
// constants, register map and state types of the serial receiver status block
// ============================================================
// Summary of operation
// - new character with data register still full sets overrun; new character and errors dropped
// - overrun clears after status read seeing it set, then a data register read
// - seven samples taken in start bit, three in each data and stop bit
// - any disagreeing sample in a bit sets noise together with receive-full
// - noise clears by status read followed by data register read
// - stop bit sampled as 0 sets framing error together with receive-full
// - parity enabled and received parity wrong sets parity error with receive-full
// - any stop mode halts all transmit and receive progress
// - the deep stop mode loses all register contents
// - light stop mode keeps all registers and resumes where it stopped
// - with internal link on, source bit 0 selects loop, 1 selects single wire
// - loop mode feeds transmitter output to receiver and frees receive pin
// - single wire feeds receiver from transmitter output and pin, frees receive pin
// - single wire, direction 0: pin is receiver input, transmitter disconnected
// - single wire, direction 1: transmitter drives the pin
// - receive-full sets when a character moves into the data register
package srx_pkg;
  // ============================================================
  // oversampling
  localparam int OVS_BITS = 4;
  localparam logic [3:0] T_LAST = 4'hf;
  localparam logic [3:0] START_WIN_LO = 4'h2;
  localparam logic [3:0] START_WIN_HI = 4'h8;
  localparam logic [3:0] BIT_WIN_LO = 4'h7;
  localparam logic [3:0] BIT_WIN_HI = 4'h9;
  localparam logic [3:0] STOP_DONE = 4'ha;
  localparam logic [2:0] START_FALSE = 3'h4;
  localparam logic [2:0] BIT_ONE = 3'h2;
  localparam logic [2:0] BIT_ALL = 3'h3;
  localparam logic [3:0] LAST_BIT_NOPAR = 4'h7;
  localparam logic [3:0] LAST_BIT_PAR = 4'h8;
  // ============================================================
  // register offsets
  localparam logic [2:0] OFF_BAUD = 3'h0;
  localparam logic [2:0] OFF_CTRL1 = 3'h1;
  localparam logic [2:0] OFF_CTRL3 = 3'h2;
  localparam logic [2:0] OFF_STAT = 3'h4;
  localparam logic [2:0] OFF_DATA = 3'h7;
  // ============================================================
  // field positions
  localparam int C1_RXEN = 0;
  localparam int C1_TXEN = 1;
  localparam int C1_PAR = 2;
  localparam int C1_ODD = 3;
  localparam int C1_RECEIVER_SOURCE_SEL = 5;
  localparam int C1_INTERNAL_LINK_SEL = 7;
  localparam int C3_SINGLE_WIRE_DIR = 5;
  localparam int S_TXIDLE = 7;
  localparam int S_RXFULL = 5;
  localparam int S_OVR = 3;
  localparam int S_NF = 2;
  localparam int S_FE = 1;
  localparam int S_PF = 0;
  // ============================================================
  // reset values
  localparam logic [7:0] BAUD_RST = 8'h04;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ============================================================
  // types
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srx_bus_t;
  typedef struct packed {
    logic full;
    logic ovr;
    logic noise;
    logic frame;
    logic parity;
  } srx_flags_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} srx_rx_st_t;
  typedef enum logic {TX_IDLE, TX_SEND} srx_tx_st_t;
  typedef struct packed {
    logic [7:0] cnt;
  } srx_baud_t;
  typedef struct packed {
    srx_tx_st_t st;
    logic [3:0] tcnt;
    logic [3:0] left;
    logic [10:0] shift;
    logic line;
  } srx_tx_t;
  typedef struct packed {
    logic [7:0] baud_div;
    logic [7:0] ctrl1;
    logic [7:0] ctrl3;
    srx_rx_st_t rx_st;
    logic [3:0] tcnt;
    logic [3:0] bcnt;
    logic [2:0] ones;
    logic noise;
    logic par_acc;
    logic [8:0] shift;
    logic [7:0] data;
    srx_flags_t flags;
    srx_flags_t arm;
    logic [7:0] rdata;
  } srx_rx_t;
endpackage : srx_pkg

// *** hw/srx_baud.sv ***
// oversampling tick generator for the serial block
`timescale 1ns/100ps
module srx_baud
  import srx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_halt,
  input wire logic i_clear,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  // ============================================================
  // state
  srx_baud_t s;
  srx_baud_t n;

  always_comb begin
    n = s;
    o_tick = 1'b0;
    if (i_clear) begin
      n = '0;
    end else if (!i_halt) begin
      // divisor 0 ticks every clock, the period being the divisor plus one, so the receiver never stalls
      if (s.cnt >= i_div) begin
        n.cnt = '0;
        o_tick = 1'b1;
      end else begin
        n.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : srx_baud

// *** hw/srx_tx.sv ***
// transmit shifter feeding the line, loop and single-wire paths
`timescale 1ns/100ps
module srx_tx
  import srx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_halt,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_en,
  input wire logic i_par_on,
  input wire logic i_odd,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic o_idle,
  output logic o_line
);
  // ============================================================
  // state
  srx_tx_t s;
  srx_tx_t n;

  assign o_idle = (s.st == TX_IDLE);
  assign o_line = s.line;

  always_comb begin
    n = s;
    if (i_clear) begin
      n = '0;
      n.line = 1'b1;
    end else if (!i_halt) begin
      case (s.st)
        TX_IDLE: begin
          n.line = 1'b1;
          // a write while busy is dropped; software polls the idle bit
          if (i_load && i_en) begin
            n.st = TX_SEND;
            n.tcnt = '0;
            n.left = i_par_on ? 4'hb : 4'ha;
            n.shift = {1'b1, i_par_on ? (^i_data ^ i_odd) : 1'b1, i_data, 1'b0};
          end
        end
        TX_SEND: begin
          if (i_tick) begin
            n.tcnt = s.tcnt + 4'h1;
            if (s.tcnt == 4'h0) begin
              n.line = s.shift[0];
              n.shift = {1'b1, s.shift[10:1]};
              n.left = s.left - 4'h1;
            end
            if (s.tcnt == T_LAST && s.left == 4'h0) begin
              n.st = TX_IDLE;
            end
          end
        end
        default: n.st = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.line <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule : srx_tx

// *** hw/srx_top.sv ***
// serial receiver with status flags, stop handling, loop and single-wire modes
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module srx_top
  import srx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire srx_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_stop_light,
  input wire logic i_stop_deep,
  input wire logic i_rxd,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_txd_oe_n,
  output logic o_rxd_released
);
  // ============================================================
  // state and wires
  srx_rx_t s;
  srx_rx_t n;
  logic tick;
  logic tx_idle;
  logic tx_line;
  logic tx_load;
  logic halt;
  logic link_on;
  logic single_wire;
  logic wire_dir;
  logic rx_in;
  logic par_on;
  logic par_odd;
  logic in_start_win;
  logic in_bit_win;
  logic bit_val;
  logic bit_noisy;
  logic stop_noisy;
  logic [3:0] last_bit;
  logic [7:0] rx_char;
  logic [7:0] stat;
  srx_flags_t cleared;

  // ============================================================
  // mode decode
  assign halt = i_stop_light | i_stop_deep;
  assign link_on = s.ctrl1[C1_INTERNAL_LINK_SEL];
  assign single_wire = link_on & s.ctrl1[C1_RECEIVER_SOURCE_SEL];
  assign wire_dir = s.ctrl3[C3_SINGLE_WIRE_DIR];
  assign par_on = s.ctrl1[C1_PAR];
  assign par_odd = s.ctrl1[C1_ODD];

  // ============================================================
  // line routing
  always_comb begin
    if (!link_on) begin
      rx_in = i_rxd;
    end else if (!single_wire) begin
      rx_in = tx_line;
    end else if (wire_dir) begin
      rx_in = tx_line;
    end else begin
      rx_in = i_txd;
    end
  end

  assign o_txd = tx_line;
  // pin released only in single wire with direction 0 so the far end can drive it
  assign o_txd_oe_n = single_wire & ~wire_dir;
  assign o_rxd_released = link_on;
  assign o_rdata = s.rdata;

  // ============================================================
  // submodules
  assign tx_load = i_bus.wr & (i_bus.addr == OFF_DATA) & ~halt;

  srx_baud u_baud (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_halt(i_stop_light),
    .i_clear(i_stop_deep),
    .i_div(s.baud_div),
    .o_tick(tick)
  );

  srx_tx u_tx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_halt(i_stop_light),
    .i_clear(i_stop_deep),
    .i_tick(tick),
    .i_en(s.ctrl1[C1_TXEN]),
    .i_par_on(par_on),
    .i_odd(par_odd),
    .i_load(tx_load),
    .i_data(i_bus.wdata),
    .o_idle(tx_idle),
    .o_line(tx_line)
  );

  // ============================================================
  // sample decode
  assign in_start_win = (s.tcnt >= START_WIN_LO) && (s.tcnt <= START_WIN_HI);
  assign in_bit_win = (s.tcnt >= BIT_WIN_LO) && (s.tcnt <= BIT_WIN_HI);
  assign bit_val = (s.ones >= BIT_ONE);
  assign bit_noisy = (s.ones != 3'h0) && (s.ones != BIT_ALL);
  assign stop_noisy = bit_noisy;
  assign last_bit = par_on ? LAST_BIT_PAR : LAST_BIT_NOPAR;
  // without parity only eight bits shift in, leaving the character one place high
  assign rx_char = par_on ? s.shift[7:0] : s.shift[8:1];

  always_comb begin
    stat = 8'h00;
    stat[S_TXIDLE] = tx_idle;
    stat[S_RXFULL] = s.flags.full;
    stat[S_OVR] = s.flags.ovr;
    stat[S_NF] = s.flags.noise;
    stat[S_FE] = s.flags.frame;
    stat[S_PF] = s.flags.parity;
  end

  // flags armed by a status read drop on the following data read
  assign cleared = srx_flags_t'(s.flags & ~s.arm);

  // ============================================================
  // next state
  always_comb begin
    n = s;
    n.rdata = 8'h00;
    if (i_stop_deep) begin
      // deep stop loses everything; software must set the block up again
      n = '0;
      n.baud_div = BAUD_RST;
      n.ctrl1 = CTRL_RST;
      n.ctrl3 = CTRL_RST;
    end else if (i_stop_light) begin
      // light stop holds every bit but the read answer, a frame in flight resumes on exit
      n = s;
      // a read answer never lingers through the stop
      n.rdata = 8'h00;
    end else begin
      // ----- register writes
      if (i_bus.wr) begin
        case (i_bus.addr)
          OFF_BAUD: n.baud_div = i_bus.wdata;
          OFF_CTRL1: n.ctrl1 = i_bus.wdata;
          OFF_CTRL3: n.ctrl3 = i_bus.wdata;
          default: n.ctrl3 = s.ctrl3;
        endcase
      end
      // ----- register reads
      if (i_bus.rd) begin
        case (i_bus.addr)
          OFF_BAUD: n.rdata = s.baud_div;
          OFF_CTRL1: n.rdata = s.ctrl1;
          OFF_CTRL3: n.rdata = s.ctrl3;
          OFF_STAT: begin
            n.rdata = stat;
            n.arm = s.flags;
          end
          OFF_DATA: begin
            n.rdata = s.data;
            n.flags = cleared;
            n.arm = '0;
          end
          default: n.rdata = 8'h00;
        endcase
      end
      // ----- receiver, applied after the clear so a set wins
      if (!s.ctrl1[C1_RXEN]) begin
        n.rx_st = RX_IDLE;
      end else if (tick) begin
        case (s.rx_st)
          RX_IDLE: begin
            if (!rx_in) begin
              n.rx_st = RX_START;
              n.tcnt = 4'h1;
              n.ones = 3'h0;
              n.bcnt = 4'h0;
              n.noise = 1'b0;
              n.par_acc = 1'b0;
            end
          end
          RX_START: begin
            n.tcnt = s.tcnt + 4'h1;
            if (in_start_win) begin
              n.ones = s.ones + {2'b00, rx_in};
            end
            if (s.tcnt == T_LAST) begin
              n.ones = 3'h0;
              // a mostly high start bit is a glitch, not a frame
              if (s.ones >= START_FALSE) begin
                n.rx_st = RX_IDLE;
              end else begin
                n.noise = (s.ones != 3'h0);
                n.rx_st = RX_BITS;
              end
            end
          end
          RX_BITS: begin
            n.tcnt = s.tcnt + 4'h1;
            if (in_bit_win) begin
              n.ones = s.ones + {2'b00, rx_in};
            end
            if (s.tcnt == T_LAST) begin
              n.ones = 3'h0;
              n.shift = {bit_val, s.shift[8:1]};
              n.par_acc = s.par_acc ^ bit_val;
              n.noise = s.noise | bit_noisy;
              n.bcnt = s.bcnt + 4'h1;
              if (s.bcnt == last_bit) begin
                n.rx_st = RX_STOP;
              end
            end
          end
          RX_STOP: begin
            n.tcnt = s.tcnt + 4'h1;
            if (in_bit_win) begin
              n.ones = s.ones + {2'b00, rx_in};
            end
            // resolve right after the stop window so a following start is not missed
            if (s.tcnt == STOP_DONE) begin
              n.rx_st = RX_IDLE;
              n.ones = 3'h0;
              if (n.flags.full) begin
                n.flags.ovr = 1'b1;
              end else begin
                n.data = rx_char;
                n.flags.full = 1'b1;
                n.flags.noise = s.noise | stop_noisy;
                n.flags.frame = ~bit_val;
                n.flags.parity = par_on & (s.par_acc ^ par_odd);
              end
            end
          end
          default: n.rx_st = RX_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.baud_div <= BAUD_RST;
      s.ctrl1 <= CTRL_RST;
      s.ctrl3 <= CTRL_RST;
    end else begin
      s <= n;
    end
  end
endmodule : srx_top

// *** testbench/srx_asserts.sv ***
// port-level assertions for the serial receiver status block
`timescale 1ns/100ps
module srx_asserts
  import srx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire srx_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_stop_light,
  input wire logic i_stop_deep,
  input wire logic o_txd,
  input wire logic o_txd_oe_n,
  input wire logic o_rxd_released
);
  // ==========
  // shadow of the control registers; stop inputs block writes, deep stop wipes them
  logic [7:0] c1;
  logic [7:0] c3;
  logic run;
  assign run = !i_stop_light && !i_stop_deep;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst)
      {c1, c3} <= 16'h0000;
    else if (i_stop_deep)
      {c1, c3} <= 16'h0000;
    else if (run && i_bus.wr && i_bus.addr == OFF_CTRL1)
      c1 <= i_bus.wdata;
    else if (run && i_bus.wr && i_bus.addr == OFF_CTRL3)
      c3 <= i_bus.wdata;
  end
  // ==========
  // properties
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_frozen;
    i_stop_light && !i_stop_deep ##1 1'b1;
  endsequence
  sequence s_flag_seen;
    i_bus.rd && i_bus.addr == OFF_STAT && run ##1 |o_rdata[2:0];
  endsequence
  AST_TX_FROZEN: assert property (s_frozen |-> $stable(o_txd))
    else $error("tx line moved in light stop");
  AST_PINS_FROZEN: assert property (s_frozen |-> $stable(o_txd_oe_n) && $stable(o_rxd_released))
    else $error("pin routing moved in light stop");
  AST_STOP_NOREAD: assert property ((i_stop_light || i_stop_deep) && i_bus.rd |=> o_rdata == 8'h00)
    else $error("read answered during stop");
  AST_DEEP_CLR: assert property (i_stop_deep |=> o_txd && !o_rxd_released && !o_txd_oe_n)
    else $error("deep stop kept state");
  AST_OE: assert property (o_txd_oe_n == (c1[C1_INTERNAL_LINK_SEL] && c1[C1_RECEIVER_SOURCE_SEL] && !c3[C3_SINGLE_WIRE_DIR]))
    else $error("pin enable wrong for mode");
  AST_REL: assert property (o_rxd_released == c1[C1_INTERNAL_LINK_SEL])
    else $error("receive pin release wrong");
  AST_ERR_FULL: assert property (s_flag_seen |-> o_rdata[S_RXFULL])
    else $error("error flag without full flag");
  AST_CTRL_KEEP: assert property (i_bus.rd && i_bus.addr == OFF_CTRL1 && run |=> o_rdata == $past(c1))
    else $error("control register content lost");
endmodule : srx_asserts

// *** testbench/srx_line_model.sv ***
// remote serial transmitter driving frames onto the line
`timescale 1ns/100ps
module srx_line_model (
  input wire logic i_mclk,
  output logic o_line
);
  // ==========
  // 32 clocks a bit matches a baud divider of 1
  int bit_clks = 32;
  initial o_line = 1'b1;
  // md: 0 parity, 1 odd, 2 bad parity, 3 bad stop, 4 noise
  // a bad stop ends early so a start caught in its tail is dropped as a glitch, not a frame
  task automatic send(input logic [7:0] d, input logic [4:0] md);
    logic [10:0] f;
    int n;
    n = md[0] ? 11 : 10;
    f = {1'b1, ^d ^ md[1] ^ md[2], d, 1'b0};
    if (!md[0])
      f[9] = 1'b1;
    f[n - 1] = !md[3];
    for (int i = 0; i < n; i++)
      for (int c = 0; c < bit_clks; c++)
        @(posedge i_mclk) o_line <= (f[i] ^ (md[4] && i == 2 && c / 2 == 8)) | (i == n - 1 && c > 23);
  endtask : send
endmodule : srx_line_model

// *** testbench/tb_top.sv ***
// self-checking bench for the serial receiver status block
`timescale 1ns/100ps
module tb_top
  import srx_pkg::*;
;
  typedef struct {
    string nm;
    logic [7:0] v;
  } srx_note_t;
  logic mclk;
  logic rst = 1'b1;
  srx_bus_t bus = '0;
  logic light = 1'b0;
  logic deep = 1'b0;
  logic via_txd = 1'b0;
  logic [7:0] rdata;
  logic txd;
  logic oe_n;
  logic freed;
  logic line;
  logic pin;
  logic rd_d = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  srx_note_t notes[$];
  // ==========
  // shared pin: driven by whoever enables it, pulled up otherwise
  assign pin = !oe_n ? txd : (via_txd ? line : 1'b1);
  srx_top u_dut (
    .i_mclk(mclk),
    .i_rst(rst),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_stop_light(light),
    .i_stop_deep(deep),
    .i_rxd(via_txd ? 1'b0 : line),
    .i_txd(pin),
    .o_txd(txd),
    .o_txd_oe_n(oe_n),
    .o_rxd_released(freed)
  );
  srx_line_model u_peer (
    .i_mclk(mclk),
    .o_line(line)
  );
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ==========
  // tasks
  task automatic conclude;
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  // reads note their expected value for the monitor
  task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk);
    bus <= '{a, d, w, !w};
    if (!w)
      notes.push_back('{$sformatf("reg%0d", a), d});
  endtask : acc
  task automatic idle(input int n);
    @(posedge mclk);
    bus <= '0;
    repeat (n - 1) @(posedge mclk);
  endtask : idle
  // a lone data read must clear nothing; status then data clears
  task automatic rx_chk(input logic [7:0] d, input logic [7:0] st);
    acc(OFF_DATA, d, 1'b0);
    acc(OFF_STAT, st, 1'b0);
    acc(OFF_DATA, d, 1'b0);
    acc(OFF_STAT, 8'h80, 1'b0);
    idle(2);
  endtask : rx_chk
  task automatic frame(input logic [7:0] d, input logic [4:0] md, input logic [7:0] st);
    u_peer.send(d, md);
    idle(4);
    rx_chk(d, st);
  endtask : frame
  // ==========
  // monitor and hang guard
  always @(posedge mclk) begin
    if (rd_d) begin
      chk(notes[0].nm, notes[0].v, rdata);
      void'(notes.pop_front());
    end
    rd_d <= bus.rd;
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      conclude();
    end
  end
  // ==========
  // main sequence
  initial begin
    logic [7:0] d;
    void'($urandom(32'h367d));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    acc(OFF_BAUD, BAUD_RST, 1'b0);
    acc(OFF_CTRL1, CTRL_RST, 1'b0);
    acc(OFF_STAT, 8'h80, 1'b0);
    acc(3'h3, 8'h00, 1'b0);
    acc(OFF_BAUD, 8'h01, 1'b1);
    acc(OFF_CTRL1, 8'h03, 1'b1);
    idle(2);
    frame(8'($urandom), 5'h00, 8'ha0);
    frame(8'($urandom), 5'h10, 8'ha4);
    frame(8'($urandom), 5'h08, 8'ha2);
    for (int k = 0; k < 8; k++) begin
      acc(OFF_CTRL1, {4'h0, k[2], 3'h7}, 1'b1);
      idle(1);
      frame(8'($urandom), {2'b00, k[1], k[0], 1'b1}, {7'h50, k[2] ^ k[1] ^ k[0]});
    end
    acc(OFF_CTRL1, 8'h03, 1'b1);
    idle(1);
    d = 8'($urandom);
    u_peer.send(d, 5'h00);
    u_peer.send(8'($urandom), 5'h18);
    idle(4);
    rx_chk(d, 8'ha8);
    // loop, single wire driving, single wire listening; receive pin held low once the link is on
    // pulling it low earlier would start a false frame that swallows the first looped start bit
    for (int k = 0; k < 3; k++) begin
      acc(OFF_CTRL3, {2'b00, k[0], 5'h00}, 1'b1);
      acc(OFF_CTRL1, {2'b10, k[1] | k[0], 5'h03}, 1'b1);
      idle(2);
      via_txd <= 1'b1;
      chk("oe_n", 8'(k == 2), 8'(oe_n));
      chk("rxd_free", 8'h01, 8'(freed));
      d = 8'($urandom);
      acc(OFF_DATA, d, 1'b1);
      idle(1);
      if (k == 2)
        u_peer.send(~d, 5'h00);
      idle(k == 2 ? 40 : 360);
      rx_chk(k == 2 ? ~d : d, 8'ha0);
    end
    d = 8'($urandom);
    u_peer.send(d, 5'h00);
    idle(4);
    light <= 1'b1;
    acc(OFF_STAT, 8'h00, 1'b0);
    acc(OFF_CTRL1, 8'h00, 1'b1);
    idle(8);
    light <= 1'b0;
    acc(OFF_CTRL1, 8'ha3, 1'b0);
    chk("oe_n", 8'h01, 8'(oe_n));
    rx_chk(d, 8'ha0);
    deep <= 1'b1;
    idle(3);
    deep <= 1'b0;
    chk("rxd_free", 8'h00, 8'(freed));
    chk("oe_n", 8'h00, 8'(oe_n));
    acc(OFF_BAUD, BAUD_RST, 1'b0);
    acc(OFF_CTRL1, CTRL_RST, 1'b0);
    acc(OFF_STAT, 8'h80, 1'b0);
    idle(3);
    conclude();
  end
endmodule : tb_top

bind srx_top srx_asserts u_chk (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_bus(i_bus),
  .o_rdata(o_rdata),
  .i_stop_light(i_stop_light),
  .i_stop_deep(i_stop_deep),
  .o_txd(o_txd),
  .o_txd_oe_n(o_txd_oe_n),
  .o_rxd_released(o_rxd_released)
);
